// ==== verilog/csl_defs.svh ====
// register map, field positions, reset values and codes of the status logic
`ifndef CSL_DEFS_SVH
`define CSL_DEFS_SVH

`define CSL_ADDR_W 8
`define CSL_CTRL_OFS 8'h00
`define CSL_STATUS_OFS 8'h04
`define CSL_IRQ_STAT_OFS 8'h08
`define CSL_IRQ_MASK_OFS 8'h0c

`define CSL_CTRL_INIT_BIT 0
`define CSL_CTRL_SIE_BIT 2
`define CSL_CTRL_RESET 3'h1

`define CSL_STS_RX_SUCCESS_FLAG_BIT 4
`define CSL_STS_TX_SUCCESS_FLAG_BIT 3
`define CSL_STS_LEC_HI 2
`define CSL_STS_LEC_LO 0

`define CSL_IRQ_STS_BIT 0
`define CSL_IRQ_ARB_BIT 1
`define CSL_IRQ_REC_BIT 2
`define CSL_IRQ_W 3

`define CSL_LEC_NONE 3'h0
`define CSL_LEC_STUFF 3'h1
`define CSL_LEC_FORM 3'h2
`define CSL_LEC_ACK 3'h3
`define CSL_LEC_BIT1 3'h4
`define CSL_LEC_BIT0 3'h5
`define CSL_LEC_CRC 3'h6
`define CSL_LEC_NOEVT 3'h7

`define CSL_STUFF_LIMIT 5
`define CSL_IDLE_BITS 11
`define CSL_IDLE_RUNS 129

`endif

// ==== verilog/csl_pkg.sv ====
// types shared by the status and error-code logic
`default_nettype none
package csl_pkg;

  typedef struct packed {
    logic rx_ok;
    logic tx_done;
    logic ack_seen;
    logic form_err;
    logic crc_err;
  } csl_frame_evt_t;

  typedef struct packed {
    logic bit_tick;
    logic tx_active;
    logic in_arb;
    logic stuff_region;
    logic tx_bit;
    logic rx_bit;
  } csl_bit_t;

  typedef enum logic [1:0] {
    CSL_REC_IDLE,
    CSL_REC_WAIT,
    CSL_REC_COUNT
  } csl_rec_state_t;

endpackage

`default_nettype wire

// ==== verilog/csl_status.sv ====
// status flags, last error code, bus-off recovery monitor and register port
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "csl_defs.svh"
`default_nettype none

module csl_status
  import csl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`CSL_ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire csl_frame_evt_t frame_evt,
  input wire csl_bit_t bit_in,
  input wire logic bus_off,
  output logic arb_lost,
  output logic err_cnt_reset,
  output logic recovering,
  output logic init_mode,
  output logic irq
);

  // highest code wins when several errors land in one cycle
  function automatic logic [2:0] lec_pick(input logic [6:0] hit);
    logic [2:0] c;
    c = `CSL_LEC_NONE;
    if (hit[0])
      c = `CSL_LEC_STUFF;
    if (hit[1])
      c = `CSL_LEC_FORM;
    if (hit[2])
      c = `CSL_LEC_ACK;
    if (hit[3])
      c = `CSL_LEC_BIT1;
    if (hit[4] || hit[5])
      c = `CSL_LEC_BIT0;
    if (hit[6])
      c = `CSL_LEC_CRC;
    return c;
  endfunction

  logic rx_ok_r;
  logic tx_ok_r;
  logic [2:0] lec_r;
  logic init_r;
  logic sie_r;
  logic [`CSL_IRQ_W-1:0] irq_stat_r;
  logic [`CSL_IRQ_W-1:0] irq_mask_r;
  logic [2:0] stuff_run_r;
  logic last_rx_r;
  logic [3:0] high_run_r;
  logic [7:0] idle_runs_r;
  logic bus_off_d_r;
  csl_rec_state_t rec_state_r;

  logic wr_ctrl;
  logic wr_sts;
  logic wr_istat;
  logic wr_imask;
  logic rd_sts;
  logic mismatch;
  logic bit1_err;
  logic bit0_err;
  logic stuff_err;
  logic idle_seen;
  logic idle_post;
  logic rec_done;
  logic rx_set;
  logic tx_set;
  logic ok_clear;
  logic [6:0] err_hit;
  logic lec_bus_v;
  logic [2:0] lec_bus;
  logic sts_chg;
  logic rx_ok_nxt;
  logic tx_ok_nxt;
  logic [2:0] lec_nxt;
  logic [`CSL_IRQ_W-1:0] irq_set;
  logic [`CSL_IRQ_W-1:0] irq_stat_nxt;

  assign wr_ctrl = wr_en && (addr == `CSL_CTRL_OFS);
  assign wr_sts = wr_en && (addr == `CSL_STATUS_OFS);
  assign wr_istat = wr_en && (addr == `CSL_IRQ_STAT_OFS);
  assign wr_imask = wr_en && (addr == `CSL_IRQ_MASK_OFS);
  assign rd_sts = rd_en && (addr == `CSL_STATUS_OFS);

  // own bit versus sampled bus level while transmitting
  assign mismatch = bit_in.bit_tick && bit_in.tx_active && (bit_in.tx_bit != bit_in.rx_bit);
  assign bit1_err = mismatch && !bit_in.in_arb && bit_in.tx_bit;
  assign bit0_err = mismatch && !bit_in.in_arb && !bit_in.tx_bit;

  // sixth equal bit in a row inside the stuffed region
  assign stuff_err = bit_in.bit_tick && bit_in.stuff_region && (bit_in.rx_bit == last_rx_r)
    && (stuff_run_r == 3'(`CSL_STUFF_LIMIT));

  assign idle_seen = bit_in.bit_tick && bit_in.rx_bit
    && (high_run_r == 4'(`CSL_IDLE_BITS - 1));
  assign idle_post = (rec_state_r == CSL_REC_COUNT) && idle_seen;
  assign rec_done = idle_post && (idle_runs_r == 8'(`CSL_IDLE_RUNS - 1));

  assign rx_set = frame_evt.rx_ok;
  assign tx_set = frame_evt.tx_done && frame_evt.ack_seen;
  assign ok_clear = rx_set || tx_set;

  assign err_hit = {frame_evt.crc_err,
                    idle_post,
                    bit0_err,
                    bit1_err,
                    frame_evt.tx_done && !frame_evt.ack_seen,
                    frame_evt.form_err,
                    stuff_err};
  // hardware codes stop at crc, so code seven only ever comes from a write
  assign lec_bus_v = (|err_hit) || ok_clear;
  assign lec_bus = lec_pick(err_hit);

  // bus value first, cpu write second
  assign rx_ok_nxt = rx_set ? 1'b1 : (wr_sts ? wr_data[`CSL_STS_RX_SUCCESS_FLAG_BIT] : rx_ok_r);
  assign tx_ok_nxt = tx_set ? 1'b1 : (wr_sts ? wr_data[`CSL_STS_TX_SUCCESS_FLAG_BIT] : tx_ok_r);
  assign lec_nxt = lec_bus_v ? lec_bus
    : (wr_sts ? wr_data[`CSL_STS_LEC_HI:`CSL_STS_LEC_LO] : lec_r);

  // only bus-caused differences count, so cpu writes stay silent
  assign sts_chg = (rx_set && !rx_ok_r) || (tx_set && !tx_ok_r)
    || (lec_bus_v && (lec_bus != lec_r));

  assign irq_set = {rec_done, mismatch && bit_in.in_arb, sts_chg && sie_r};
  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (wr_istat)
      irq_stat_nxt = irq_stat_nxt & ~wr_data[`CSL_IRQ_W-1:0];
    if (rd_sts)
      irq_stat_nxt[`CSL_IRQ_STS_BIT] = 1'b0;
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_ok_r <= 1'b0;
      tx_ok_r <= 1'b0;
      lec_r <= `CSL_LEC_NONE;
    end
    else
    begin
      rx_ok_r <= rx_ok_nxt;
      tx_ok_r <= tx_ok_nxt;
      lec_r <= lec_nxt;
    end
  end

  // control bits; going bus-off forces init
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_r <= 1'(`CSL_CTRL_RESET);
      sie_r <= 1'b0;
      bus_off_d_r <= 1'b0;
    end
    else
    begin
      bus_off_d_r <= bus_off;
      if (bus_off && !bus_off_d_r)
        init_r <= 1'b1;
      else if (wr_ctrl)
        init_r <= wr_data[`CSL_CTRL_INIT_BIT];
      if (wr_ctrl)
        sie_r <= wr_data[`CSL_CTRL_SIE_BIT];
    end
  end

  // run length of equal received bits in the stuffed region
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stuff_run_r <= 3'h0;
      last_rx_r <= 1'b1;
    end
    else if (bit_in.bit_tick)
    begin
      last_rx_r <= bit_in.rx_bit;
      if (!bit_in.stuff_region || bit_in.rx_bit != last_rx_r)
        stuff_run_r <= 3'h1;
      else if (stuff_run_r != 3'(`CSL_STUFF_LIMIT))
        stuff_run_r <= stuff_run_r + 3'h1;
      else
        stuff_run_r <= 3'h1;
    end
  end

  // eleven high bits form one idle run; a low bit restarts it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      high_run_r <= 4'h0;
    else if (bit_in.bit_tick)
    begin
      if (!bit_in.rx_bit || idle_seen)
        high_run_r <= 4'h0;
      else
        high_run_r <= high_run_r + 4'h1;
    end
  end

  // recovery cannot be cut short by toggling init once counting started
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rec_state_r <= CSL_REC_IDLE;
      idle_runs_r <= 8'h00;
      err_cnt_reset <= 1'b0;
    end
    else
    begin
      err_cnt_reset <= rec_done;
      case (rec_state_r)
        CSL_REC_IDLE:
        begin
          idle_runs_r <= 8'h00;
          if (bus_off)
            rec_state_r <= CSL_REC_WAIT;
        end
        CSL_REC_WAIT:
        begin
          idle_runs_r <= 8'h00;
          if (!init_r)
            rec_state_r <= CSL_REC_COUNT;
        end
        CSL_REC_COUNT:
        begin
          if (rec_done)
            rec_state_r <= CSL_REC_IDLE;
          else if (idle_post)
            idle_runs_r <= idle_runs_r + 8'h01;
        end
        default:
          rec_state_r <= CSL_REC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
      arb_lost <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_imask)
        irq_mask_r <= wr_data[`CSL_IRQ_W-1:0];
      irq <= |(irq_stat_nxt & (wr_imask ? wr_data[`CSL_IRQ_W-1:0] : irq_mask_r));
      arb_lost <= mismatch && bit_in.in_arb;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      recovering <= 1'b0;
      init_mode <= 1'b1;
    end
    else
    begin
      recovering <= (rec_state_r != CSL_REC_IDLE);
      init_mode <= init_r;
    end
  end

  // read data valid in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= 32'h0000_0000;
    else if (!rd_en)
      rd_data <= 32'h0000_0000;
    else
    begin
      case (addr)
        `CSL_CTRL_OFS:
          rd_data <= {29'h0, sie_r, 1'b0, init_r};
        `CSL_STATUS_OFS:
          rd_data <= {27'h0, rx_ok_r, tx_ok_r, lec_r};
        `CSL_IRQ_STAT_OFS:
          rd_data <= {29'h0, irq_stat_r};
        `CSL_IRQ_MASK_OFS:
          rd_data <= {29'h0, irq_mask_r};
        default:
          rd_data <= 32'h0000_0000;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== bench/csl_status_monitor.sv ====
// concurrent checks on the ports of the status logic
`timescale 1ns/1ps
`default_nettype none
`include "csl_defs.svh"
module csl_status_monitor
  import csl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`CSL_ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire csl_frame_evt_t frame_evt,
  input wire csl_bit_t bit_in,
  input wire logic bus_off,
  input wire logic arb_lost,
  input wire logic err_cnt_reset,
  input wire logic recovering,
  input wire logic init_mode,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic arb_mis;
  logic sts_rd;
  logic evt_quiet;
  // nothing that could move the status fields in the cycle between event and read
  assign evt_quiet = !wr_en && !bit_in.bit_tick && (frame_evt == 5'h00);
  assign arb_mis = bit_in.bit_tick && bit_in.tx_active && bit_in.in_arb
    && (bit_in.tx_bit != bit_in.rx_bit);
  assign sts_rd = rd_en && (addr == `CSL_STATUS_OFS);
  a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not zero outside its slot");
  a_arb_lost_set: assert property (arb_mis |=> arb_lost)
    else $error("arbitration mismatch not reported");
  a_arb_lost_cause: assert property (arb_lost |-> $past(arb_mis))
    else $error("arbitration loss without mismatch");
  a_status_upper: assert property (sts_rd |=> rd_data[31:5] == 27'h0)
    else $error("status bits above fields not zero");
  a_rx_flag_set: assert property (frame_evt.rx_ok ##1 !wr_en ##1 sts_rd |=> rd_data[4])
    else $error("receive flag not set");
  a_tx_flag_set: assert property (frame_evt.tx_done && frame_evt.ack_seen ##1 !wr_en
    ##1 sts_rd |=> rd_data[3])
    else $error("transmit flag not set");
  a_ack_err_code: assert property (frame_evt == 5'h08 && !bit_in.bit_tick ##1 evt_quiet
    ##1 sts_rd |=> rd_data[2:0] == 3'h3)
    else $error("ack error code missing");
  a_crc_err_code: assert property (frame_evt.crc_err ##1 evt_quiet ##1 sts_rd
    |=> rd_data[2:0] == 3'h6)
    else $error("crc error code missing");
  a_recov_pulse: assert property (err_cnt_reset |=> !err_cnt_reset)
    else $error("counter reset longer than one cycle");
  a_init_on_boff: assert property ($rose(bus_off) |-> ##[1:3] init_mode)
    else $error("bus-off did not force init");
  cover property (arb_lost);
  cover property (err_cnt_reset);
  cover property (irq);
endmodule
bind csl_status csl_status_monitor mon_u (.clk(clk), .rst_b(rst_b), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .frame_evt(frame_evt),
  .bit_in(bit_in), .bus_off(bus_off), .arb_lost(arb_lost), .err_cnt_reset(err_cnt_reset),
  .recovering(recovering), .init_mode(init_mode), .irq(irq));
`default_nettype wire

// ==== bench/csl_bus_node.sv ====
// other nodes on the bus: bit ticks and the sampled bus level
`timescale 1ns/1ps
`default_nettype none
module csl_bus_node (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic level,
  output logic tick,
  output logic rx_bit
);
  logic ph_r;
  // free phase, so an even number n of active cycles always gives n/2 ticks
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ph_r <= 1'b0;
    else
      ph_r <= ~ph_r;
  end
  assign tick = run & ph_r;
  // released bus floats recessive high
  assign rx_bit = run ? level : 1'b1;
endmodule
`default_nettype wire

// ==== bench/csl_status_test.sv ====
// self-checking bench for the status and error-code logic
`timescale 1ns/1ps
`default_nettype none
`include "csl_defs.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module csl_status_test;
  import csl_pkg::*;
  typedef struct packed {logic [4:0] evt; logic [31:0] exp;} csl_row_t;
  logic clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, bus_off = 0, run = 0, level = 1;
  logic tx_active = 0, in_arb = 0, stf = 0, tx_bit = 1, tick, rx_bit, done_seen = 0;
  logic [7:0] addr = 0;
  logic [31:0] wr_data = 0, rd_data;
  logic arb_lost, err_cnt_reset, recovering, init_mode, irq;
  csl_frame_evt_t frame_evt = '0;
  csl_bit_t bit_in;
  int bad_count = 0, samples_checked = 0;
  csl_row_t rows [5] = '{'{5'h10, 32'h10}, '{5'h0c, 32'h08}, '{5'h08, 32'h03},
    '{5'h02, 32'h02}, '{5'h01, 32'h06}};
  logic [31:0] rst_exp [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
  assign bit_in = {tick, tx_active, in_arb, stf, tx_bit, rx_bit};
  always #50 clk = ~clk;
  always @(posedge clk) if (err_cnt_reset === 1'b1) done_seen <= 1'b1;
  csl_status dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .frame_evt(frame_evt), .bit_in(bit_in),
    .bus_off(bus_off), .arb_lost(arb_lost), .err_cnt_reset(err_cnt_reset),
    .recovering(recovering), .init_mode(init_mode), .irq(irq));
  csl_bus_node node_u (.clk(clk), .rst_b(rst_b), .run(run), .level(level), .tick(tick),
    .rx_bit(rx_bit));
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, e)
  endtask
  task automatic evt(input logic [4:0] e);
    @(posedge clk);
    frame_evt <= e;
    @(posedge clk);
    frame_evt <= '0;
    #1;
  endtask
  // f holds tx_active, in_arb, stuff region, tx bit
  task automatic bits(input logic [3:0] f, input logic l, input int n);
    @(posedge clk);
    {tx_active, in_arb, stf, tx_bit} <= f;
    level <= l;
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #1200000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(i * 4), rst_exp[i]);
    rd(8'h10, 32'h0);
    wr(`CSL_STATUS_OFS, 32'h7);
    rd(`CSL_STATUS_OFS, 32'h7);
    wr(`CSL_STATUS_OFS, 32'h1f);
    rd(`CSL_STATUS_OFS, 32'h1f);
    $display("register test done");
    foreach (rows[i])
    begin
      wr(`CSL_STATUS_OFS, 32'h7);
      evt(rows[i].evt);
      rd(`CSL_STATUS_OFS, rows[i].exp);
    end
    $display("frame event test done");
    wr(`CSL_STATUS_OFS, 32'h0);
    bits(4'b1001, 1'b0, 4);
    rd(`CSL_STATUS_OFS, 32'h4);
    bits(4'b1000, 1'b1, 4);
    rd(`CSL_STATUS_OFS, 32'h5);
    wr(`CSL_STATUS_OFS, 32'h0);
    bits(4'b1101, 1'b0, 4);
    rd(`CSL_STATUS_OFS, 32'h0);
    bits(4'b0010, 1'b0, 2);
    bits(4'b0010, 1'b1, 10);
    rd(`CSL_STATUS_OFS, 32'h0);
    bits(4'b0010, 1'b1, 2);
    rd(`CSL_STATUS_OFS, 32'h1);
    $display("bit error test done");
    wr(`CSL_IRQ_STAT_OFS, 32'h7);
    wr(`CSL_CTRL_OFS, 32'h4);
    wr(`CSL_IRQ_MASK_OFS, 32'h1);
    evt(5'h10);
    `CHK(irq, 1'b1)
    rd(`CSL_IRQ_STAT_OFS, 32'h1);
    wr(`CSL_IRQ_MASK_OFS, 32'h0);
    `CHK(irq, 1'b0)
    wr(`CSL_IRQ_MASK_OFS, 32'h1);
    rd(`CSL_STATUS_OFS, 32'h10);
    `CHK(irq, 1'b0)
    wr(`CSL_STATUS_OFS, 32'h1f);
    rd(`CSL_IRQ_STAT_OFS, 32'h0);
    $display("interrupt test done");
    @(posedge clk);
    bus_off <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(init_mode, 1'b1)
    wr(`CSL_CTRL_OFS, 32'h4);
    wr(`CSL_STATUS_OFS, 32'h0);
    bits(4'b0000, 1'b0, 2);
    bits(4'b0000, 1'b1, 30);
    rd(`CSL_STATUS_OFS, 32'h5);
    `CHK(recovering, 1'b1)
    bits(4'b0000, 1'b1, 2806);
    repeat (3) @(posedge clk);
    `CHK(done_seen, 1'b0)
    bits(4'b0000, 1'b1, 2);
    repeat (3) @(posedge clk);
    `CHK(done_seen, 1'b1)
    rd(`CSL_IRQ_STAT_OFS, 32'h4);
    $display("recovery test done");
    complete_run();
  end
endmodule
`default_nettype wire
